/* shared/sds_cfg.svh */
`ifndef SDS_CFG_SVH
`define SDS_CFG_SVH

// Lane count and bits per lane word at the widest ratio.
`define SDS_LANES     16
`define SDS_LANE_W    8

// Conversion ratio codes.
`define SDS_R8        2'h0
`define SDS_R7        2'h1
`define SDS_R4        2'h2
`define SDS_R1        2'h3

// Last bit count of a frame for each ratio (ratio minus one).
`define SDS_LAST8     3'h7
`define SDS_LAST7     3'h6
`define SDS_LAST4     3'h3
`define SDS_LAST1     3'h0

// Valid bit masks of a lane word for each ratio.
`define SDS_MASK8     8'hFF
`define SDS_MASK7     8'h7F
`define SDS_MASK4     8'h0F
`define SDS_MASK1     8'h01

// Training word hunted on lane 0 during alignment.
`define SDS_TRAIN     8'h9C

// Transmit frame: fixed 8:1, forwarded clock high for the first half.
`define SDS_TX_LAST   3'h7
`define SDS_TX_HALF   3'h4

// Reset values.
`define SDS_CFG_RST   4'h0

`endif

/* shared/sds_pkg.sv */
`include "sds_cfg.svh"

package sds_pkg;

  // Alignment progress of the receive word boundary.
  typedef enum logic [1:0] {
    SDS_AL_IDLE,
    SDS_AL_HUNT,
    SDS_AL_LOCK
  } sds_align_e;

  // Last bit count of a receive frame for a ratio code.
  function automatic logic [2:0] sds_last(input logic [1:0] ratio);
    logic [2:0] last;
    last = `SDS_LAST8;
    case (ratio)
      `SDS_R7: last = `SDS_LAST7;
      `SDS_R4: last = `SDS_LAST4;
      `SDS_R1: last = `SDS_LAST1;
      default: last = `SDS_LAST8;
    endcase
    return last;
  endfunction

  // Mask of the lane word bits that a ratio fills.
  function automatic logic [7:0] sds_mask(input logic [1:0] ratio);
    logic [7:0] mask;
    mask = `SDS_MASK8;
    case (ratio)
      `SDS_R7: mask = `SDS_MASK7;
      `SDS_R4: mask = `SDS_MASK4;
      `SDS_R1: mask = `SDS_MASK1;
      default: mask = `SDS_MASK8;
    endcase
    return mask;
  endfunction

endpackage

/* src/sds_serdes.sv */
// Behaviour
// - Every receive lane can be set to bypass the converter, its raw bit stream then going straight to the core.
// - The receiver builds one lane word from eight, seven, four or one serial bits as configured.
// - The serial clock runs at the ratio times the reference rate, so one frame spans ratio serial clocks.
// - In the 8, 7 and 4 modes the receive clock is aligned to the data before words are trusted.
// - Alignment moves the sampling boundary of the multiplied clock until it lines up with the data.
// - Sixteen lanes are deserialized into a bus of up to 128 bits from one shared receive clock.
// - Up to 128 parallel bits are serialized onto sixteen lanes at 8:1 on the same link clock as the receive side.
// - No serial clock is derived above eight times the reference rate.
// - The transmitter can forward a reference-rate clock whose edges are in phase with the serial data.
// - Each frame moves up to 128 bits in each direction between the parallel and serial sides.
// - In the 8, 7 and 4 modes a word-rate clock from the receive serial clock is offered to the core logic.
// - Every receive lane has its own shift register and every transmit lane its own loaded shift register.
`timescale 1ns/10ps
`default_nettype none
`include "sds_cfg.svh"

module sds_serdes
  import sds_pkg::*;
#(
  parameter int LANES = `SDS_LANES,
  parameter int LW    = `SDS_LANE_W
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               clk_link,
  input  wire logic [LANES-1:0]   rx_serial,
  input  wire logic [1:0]         ratio_sel,
  input  wire logic [LANES-1:0]   lane_bypass,
  input  wire logic               align_req,
  input  wire logic               fwd_clk_en,
  input  wire logic [LANES*LW-1:0] tx_data,
  input  wire logic               tx_valid,
  output logic      [LANES*LW-1:0] rx_data,
  output logic                    rx_valid,
  output logic                    rx_locked,
  output logic      [LANES-1:0]   rx_bypass_bits,
  output logic                    rx_word_clk,
  output logic                    tx_ready,
  output logic      [LANES-1:0]   tx_serial,
  output logic                    tx_fwd_clk
);

  localparam int N = LANES * LW;

  ////////////////////////////////////////////////////////////////////////////
  // State types of the two clock domains.

  typedef struct packed {
    logic [3:0]          cfg_s1;
    logic [3:0]          cfg_s2;
    logic [3:0]          cfg_s3;
    logic [3:0]          cfg;
    logic [LANES-1:0]    rxs;
    logic [N-1:0]        sh;
    logic [2:0]          rcnt;
    logic                slip;
    sds_align_e          al;
    logic [1:0][N-1:0]   hold;
    logic                rtog;
    logic                wclk;
    logic                req_s1;
    logic                req_s2;
    logic                req_s3;
    logic                ack;
    logic [N-1:0]        tsh;
    logic [2:0]          tcnt;
    logic [LANES-1:0]    tx_out;
    logic                fwd;
  } sds_lnk_s;

  typedef struct packed {
    logic                rtog_s1;
    logic                rtog_s2;
    logic                rtog_s3;
    logic                racc;
    logic [N-1:0]        rx_data;
    logic                rx_valid;
    logic                lock_s1;
    logic                lock_s2;
    logic                lock_s3;
    logic                rx_locked;
    logic [LANES-1:0]    byp_s1;
    logic [LANES-1:0]    byp_s2;
    logic [LANES-1:0]    byp_s3;
    logic [LANES-1:0]    rx_bypass;
    logic [N-1:0]        tx_hold;
    logic                treq;
    logic                ack_s1;
    logic                ack_s2;
    logic                ack_s3;
    logic                tx_ready;
  } sds_sys_s;

  sds_lnk_s lk_r;
  sds_lnk_s lk_nxt;
  sds_sys_s sy_r;
  sds_sys_s sy_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain reset: asserted at once, released on the link clock.

  logic [1:0] lrst_q;
  logic       rst_link;

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      lrst_q <= 2'h3;
    end else begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end

  assign rst_link = lrst_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: receive shifters, alignment, transmit shifters.

  always_comb begin
    logic [2:0] last;
    logic [7:0] mask;
    logic       frame_end;
    logic       match;
    lk_nxt    = lk_r;
    last      = sds_last(lk_r.cfg[1:0]);
    mask      = sds_mask(lk_r.cfg[1:0]);
    frame_end = 1'b0;
    match     = 1'b0;

    // Configuration levels; a change counts once the second and third stages agree.
    lk_nxt.cfg_s1 = {fwd_clk_en, align_req, ratio_sel};
    lk_nxt.cfg_s2 = lk_r.cfg_s1;
    lk_nxt.cfg_s3 = lk_r.cfg_s2;
    if (lk_r.cfg_s2 == lk_r.cfg_s3) begin
      lk_nxt.cfg = lk_r.cfg_s3;
    end

    // Serial pins are launched on the link clock by the partner, so one stage suffices.
    lk_nxt.rxs = rx_serial;

    // One shifter per lane, first bit ends up at the top of the word.
    for (int l = 0; l < LANES; l++) begin
      lk_nxt.sh[l*LW +: LW] = {lk_r.sh[l*LW +: LW-1], lk_r.rxs[l]};
    end

    // Frame counter; a pending slip stretches one frame by a bit, moving the boundary.
    if (lk_r.rcnt >= last) begin
      if (lk_r.slip) begin
        lk_nxt.slip = 1'b0;
      end else begin
        frame_end   = 1'b1;
        lk_nxt.rcnt = 3'h0;
      end
    end else begin
      lk_nxt.rcnt = lk_r.rcnt + 3'h1;
    end
    lk_nxt.wclk = (lk_nxt.rcnt <= (last >> 1));

    // Completed words go to alternate hold slots so the parallel side has a full frame to read.
    if (frame_end) begin
      for (int l = 0; l < LANES; l++) begin
        lk_nxt.hold[~lk_r.rtog][l*LW +: LW] = lk_nxt.sh[l*LW +: LW] & mask;
      end
      lk_nxt.rtog = ~lk_r.rtog;
      match = ((lk_nxt.sh[LW-1:0] & mask) == (`SDS_TRAIN & mask));
    end

    // Boundary alignment against the training word on lane 0, shared by all lanes.
    if (lk_nxt.cfg[1:0] != lk_r.cfg[1:0]) begin
      lk_nxt.al   = SDS_AL_IDLE;
      lk_nxt.slip = 1'b0;
    end else if (lk_r.cfg[1:0] == `SDS_R1) begin
      lk_nxt.al = SDS_AL_LOCK;
    end else if (lk_nxt.cfg[2] && !lk_r.cfg[2]) begin
      lk_nxt.al = SDS_AL_HUNT;
    end else if (frame_end && lk_r.al == SDS_AL_HUNT) begin
      if (match) begin
        lk_nxt.al = SDS_AL_LOCK;
      end else begin
        lk_nxt.slip = 1'b1;
      end
    end

    // Transmit request toggle from the parallel side.
    lk_nxt.req_s1 = sy_r.treq;
    lk_nxt.req_s2 = lk_r.req_s1;
    lk_nxt.req_s3 = lk_r.req_s2;

    // Fixed 8:1 transmit frame; a pending word is loaded at the boundary, else idle zeros.
    if (lk_r.tcnt == `SDS_TX_LAST) begin
      lk_nxt.tcnt = 3'h0;
      if (lk_r.req_s2 == lk_r.req_s3 && lk_r.req_s3 != lk_r.ack) begin
        lk_nxt.tsh = sy_r.tx_hold;
        lk_nxt.ack = lk_r.req_s3;
      end else begin
        lk_nxt.tsh = '0;
      end
    end else begin
      lk_nxt.tcnt = lk_r.tcnt + 3'h1;
      for (int l = 0; l < LANES; l++) begin
        lk_nxt.tsh[l*LW +: LW] = {lk_r.tsh[l*LW +: LW-1], 1'b0};
      end
    end
    for (int l = 0; l < LANES; l++) begin
      lk_nxt.tx_out[l] = lk_nxt.tsh[l*LW + LW-1];
    end

    // Forwarded clock at reference rate: high over the first four bits of each word.
    lk_nxt.fwd = lk_r.cfg[3] && (lk_nxt.tcnt < `SDS_TX_HALF);
  end

  always_ff @(posedge clk_link or posedge rst_link) begin
    if (rst_link) begin
      lk_r        <= '0;
      lk_r.cfg_s1 <= `SDS_CFG_RST;
      lk_r.cfg_s2 <= `SDS_CFG_RST;
      lk_r.cfg_s3 <= `SDS_CFG_RST;
      lk_r.cfg    <= `SDS_CFG_RST;
      lk_r.al     <= SDS_AL_IDLE;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: word delivery, bypass streams, transmit handshake.

  always_comb begin
    logic [N-1:0] word;
    sy_nxt = sy_r;
    word   = '0;

    // Receive word toggle; the hold slot it names stays still for a whole frame.
    sy_nxt.rtog_s1  = lk_r.rtog;
    sy_nxt.rtog_s2  = sy_r.rtog_s1;
    sy_nxt.rtog_s3  = sy_r.rtog_s2;
    sy_nxt.rx_valid = 1'b0;
    if (sy_r.rtog_s2 == sy_r.rtog_s3 && sy_r.rtog_s3 != sy_r.racc) begin
      word = lk_r.hold[sy_r.rtog_s3];
      for (int l = 0; l < LANES; l++) begin
        if (lane_bypass[l]) begin
          word[l*LW +: LW] = '0;
        end
      end
      sy_nxt.racc     = sy_r.rtog_s3;
      sy_nxt.rx_data  = word;
      sy_nxt.rx_valid = 1'b1;
    end

    // Lock indication, a level from the link domain.
    sy_nxt.lock_s1 = (lk_r.al == SDS_AL_LOCK);
    sy_nxt.lock_s2 = sy_r.lock_s1;
    sy_nxt.lock_s3 = sy_r.lock_s2;
    if (sy_r.lock_s2 == sy_r.lock_s3) begin
      sy_nxt.rx_locked = sy_r.lock_s3;
    end

    // Raw lane streams; only usable while the bit rate is well below the system clock.
    sy_nxt.byp_s1 = lk_r.rxs;
    sy_nxt.byp_s2 = sy_r.byp_s1;
    sy_nxt.byp_s3 = sy_r.byp_s2;
    for (int l = 0; l < LANES; l++) begin
      if (sy_r.byp_s2[l] == sy_r.byp_s3[l]) begin
        sy_nxt.rx_bypass[l] = sy_r.byp_s3[l] & lane_bypass[l];
      end
    end

    // Transmit handshake: the hold word stays still until the link side acknowledges it.
    sy_nxt.ack_s1 = lk_r.ack;
    sy_nxt.ack_s2 = sy_r.ack_s1;
    sy_nxt.ack_s3 = sy_r.ack_s2;
    if (tx_valid && sy_r.tx_ready) begin
      sy_nxt.tx_hold  = tx_data;
      sy_nxt.treq     = ~sy_r.treq;
      sy_nxt.tx_ready = 1'b0;
    end else if (!sy_r.tx_ready && sy_r.ack_s2 == sy_r.ack_s3 && sy_r.ack_s3 == sy_r.treq) begin
      sy_nxt.tx_ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sy_r          <= '0;
      sy_r.tx_ready <= 1'b1;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign rx_data        = sy_r.rx_data;
  assign rx_valid       = sy_r.rx_valid;
  assign rx_locked      = sy_r.rx_locked;
  assign rx_bypass_bits = sy_r.rx_bypass;
  assign tx_ready       = sy_r.tx_ready;
  assign rx_word_clk    = lk_r.wclk;
  assign tx_serial      = lk_r.tx_out;
  assign tx_fwd_clk     = lk_r.fwd;

endmodule

`default_nettype wire

/* tb/sds_serdes_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sds_cfg.svh"
module sds_chk #(
  parameter int LANES = 16
) (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire logic             clk_link,
  input wire logic [1:0]       ratio_sel,
  input wire logic [LANES-1:0] lane_bypass,
  input wire logic             fwd_clk_en,
  input wire logic             tx_valid,
  input wire logic             rx_valid,
  input wire logic             rx_locked,
  input wire logic [LANES-1:0] rx_bypass_bits,
  input wire logic             rx_word_clk,
  input wire logic             tx_ready,
  input wire logic             tx_fwd_clk
);
  ////////////////////
  // Forwarded clock: after each fall, four bit times low, then four high.
  sequence s_fwd_lo;
    !tx_fwd_clk[*4];
  endsequence
  sequence s_fwd_hi;
    tx_fwd_clk[*4];
  endsequence
  property p_fwd_shape;
    @(posedge clk_link) disable iff (rst) $fell(tx_fwd_clk) |-> s_fwd_lo ##1 s_fwd_hi;
  endproperty
  a_fwd_shape: assert property (p_fwd_shape) else $error("forwarded clock out of frame");
  // Config crosses late, so the enable must be settled for some link clocks.
  property p_fwd_off;
    @(posedge clk_link) disable iff (rst) (!fwd_clk_en)[*6] |-> !tx_fwd_clk;
  endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("forwarded clock while disabled");
  property p_word_clk;
    @(posedge clk_link) disable iff (rst) (ratio_sel == `SDS_R1)[*8] |-> rx_word_clk;
  endproperty
  a_word_clk: assert property (p_word_clk) else $error("word clock not steady at 1:1");
  property p_lock_1to1;
    @(posedge clk_link) disable iff (rst) (ratio_sel == `SDS_R1)[*8] |-> rx_locked;
  endproperty
  a_lock_1to1: assert property (p_lock_1to1) else $error("not locked at 1:1");
  property p_valid_pulse;
    @(posedge clk_sys) disable iff (rst) rx_valid |=> !rx_valid[*2];
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("receive strobe too long");
  property p_tx_take;
    @(posedge clk_sys) disable iff (rst) tx_valid && tx_ready |=> !tx_ready;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("ready kept after take");
  property p_tx_back;
    @(posedge clk_sys) disable iff (rst) $fell(tx_ready) |-> ##[1:200] tx_ready;
  endproperty
  a_tx_back: assert property (p_tx_back) else $error("ready never returned");
  property p_bypass_gate;
    @(posedge clk_sys) disable iff (rst) (rx_bypass_bits & ~(lane_bypass | $past(lane_bypass))) == '0;
  endproperty
  a_bypass_gate: assert property (p_bypass_gate) else $error("raw bit on converted lane");
endmodule
bind sds_serdes sds_chk #(.LANES(LANES)) u_chk (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
  .ratio_sel(ratio_sel), .lane_bypass(lane_bypass), .fwd_clk_en(fwd_clk_en), .tx_valid(tx_valid),
  .rx_valid(rx_valid), .rx_locked(rx_locked), .rx_bypass_bits(rx_bypass_bits),
  .rx_word_clk(rx_word_clk), .tx_ready(tx_ready), .tx_fwd_clk(tx_fwd_clk));
`default_nettype wire

/* tb/sds_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
module sds_far_end (
  input wire logic         clk_link,
  input wire logic         rst,
  input wire logic [3:0]   bits,
  input wire logic [127:0] word,
  output logic     [15:0]  rx_serial
);
  logic [127:0] cur;
  logic [3:0]   k;
  // A new word is latched only at a frame start, so a frame is never torn.
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      k <= 4'h0;
      cur <= '0;
      rx_serial <= '0;
    end else begin
      for (int l = 0; l < 16; l++) rx_serial[l] <= (k == 0) ? word[8*l+bits-1] : cur[8*l+k-1];
      if (k == 0) cur <= word;
      k <= (k == 0) ? bits - 4'h1 : k - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/sds_serdes_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sds_cfg.svh"
module sds_serdes_test;
  logic         clk_sys, clk_link, rst, align_req, fwd_clk_en, tx_valid, fwd_q;
  logic         rx_valid, rx_locked, rx_word_clk, tx_ready, tx_fwd_clk;
  logic [1:0]   ratio_sel;
  logic [3:0]   far_bits;
  logic [15:0]  lane_bypass, rx_serial, rx_bypass_bits, tx_serial;
  logic [127:0] tx_data, rx_data, far_word, cap, sh;
  int           mismatches, n_tests, ph;
  sds_serdes u_dut (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .rx_serial(rx_serial),
    .ratio_sel(ratio_sel), .lane_bypass(lane_bypass), .align_req(align_req), .fwd_clk_en(fwd_clk_en),
    .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .rx_locked(rx_locked),
    .rx_bypass_bits(rx_bypass_bits), .rx_word_clk(rx_word_clk), .tx_ready(tx_ready),
    .tx_serial(tx_serial), .tx_fwd_clk(tx_fwd_clk));
  sds_far_end u_far (.clk_link(clk_link), .rst(rst), .bits(far_bits), .word(far_word), .rx_serial(rx_serial));
  ////////////////////
  // The link clock is offset so its edges never meet the system clock's.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // The first rising link edge falls inside reset, so the link-side reset stage is set before any check.
  initial begin
    clk_link = 1'b0;
    #2;
    forever begin
      clk_link = ~clk_link;
      #16;
    end
  end
  // Rebuild each sent frame on the falling edge, where the serial outputs have settled.
  always @(negedge clk_link) begin
    if (tx_fwd_clk && !fwd_q) ph = 0;
    fwd_q = tx_fwd_clk;
    if (ph < 8) begin
      for (int l = 0; l < 16; l++) sh[8*l+7-ph] = tx_serial[l];
      if (ph == 7 && sh != 0) cap = sh;
      ph++;
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A second offer while busy must be ignored, not queued.
  task automatic t_tx;
    logic [127:0] w;
    fwd_clk_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      w = i ? 128'hF1E2_D3C4_B5A6_9788_7968_5A4B_3C2D_1E0F : 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
      tx_data = w;
      tx_valid = 1'b1;
      @(negedge clk_sys);
      check(128'(tx_ready), 128'h0);
      tx_data = ~w;
      repeat (3) @(negedge clk_sys);
      tx_valid = 1'b0;
      for (int n = 0; n < 200 && tx_ready !== 1'b1; n++) @(negedge clk_sys);
      repeat (24) @(posedge clk_link);
      @(negedge clk_sys);
      check(cap, w);
    end
    $display("t_tx done");
  endtask
  // Every ratio: lock (by a hunt on the training word except at 1:1), then one masked word per converted lane and the raw bit of bypassed lane 15.
  task automatic t_rx;
    logic [127:0] exp;
    lane_bypass = 16'h8000;
    for (int r = 0; r < 4; r++) begin
      ratio_sel = 2'(r);
      far_bits = (r == 0) ? 4'h8 : (r == 1) ? 4'h7 : (r == 2) ? 4'h4 : 4'h1;
      far_word = {16{`SDS_TRAIN}};
      align_req = 1'b0;
      repeat (40) @(negedge clk_sys);
      align_req = 1'b1;
      for (int n = 0; n < 600 && rx_locked !== 1'b1; n++) @(negedge clk_sys);
      check(128'(rx_locked), 128'h1);
      far_word = 128'hFF5A_C396_E10F_B47D_28A5_3C66_99D2_1E87;
      exp = far_word & {16{8'((16'h1 << far_bits) - 16'h1)}};
      exp[127:120] = 8'h00;
      repeat (3) begin
        @(negedge clk_sys);
        for (int n = 0; n < 100 && rx_valid !== 1'b1; n++) @(negedge clk_sys);
      end
      check(rx_data, exp);
      check(128'(rx_bypass_bits), 128'h8000);
    end
    $display("t_rx done");
  endtask
  initial begin
    {rst, align_req, fwd_clk_en, tx_valid, fwd_q} = 5'h10;
    {ratio_sel, lane_bypass, tx_data, far_word, cap, sh} = '0;
    far_bits = 4'h8;
    {mismatches, n_tests, ph} = {32'd0, 32'd0, 32'd8};
    repeat (2) @(negedge clk_sys);
    check(128'({tx_ready, rx_valid, rx_locked, tx_serial, tx_fwd_clk}), 128'h80000);
    rst = 1'b0;
    repeat (20) @(negedge clk_sys);
    t_tx();
    t_rx();
    stop_test();
  end
  initial begin
    #400000;
    mismatches++;
    $display("mismatch at %0t: timeout", $time);
    stop_test();
  end
endmodule
`default_nettype wire
